// ===== src/rfsw_map.svh
// register map, field positions, reset values and frame counts of the
// rf switch command decoder.
// assumes nothing; definitions only.
`ifndef RFSW_MAP_SVH
`define RFSW_MAP_SVH

// register addresses (5-bit command address field)
`define RFSW_ADDR_PATH      5'h00
`define RFSW_ADDR_PMT       5'h1c
`define RFSW_ADDR_PART      5'h1d
`define RFSW_ADDR_MAKER_LO  5'h1e
`define RFSW_ADDR_MAKER_HI  5'h1f

// reset values and broadcast address
`define RFSW_PATH_RST       8'h00
`define RFSW_PMT_RST        8'h00
`define RFSW_NODE_RST       4'hb
`define RFSW_BCAST_ADDR     4'h0

// power_and_shadow_control fields
`define RFSW_PMT_LOW_POWER  7
`define RFSW_PMT_STARTUP    6
`define RFSW_PMT_MASK_HI    5
`define RFSW_PMT_MASK_LO    3
`define RFSW_PMT_TRIG_HI    2
`define RFSW_PMT_TRIG_LO    0

// command frame fields
`define RFSW_CMD_SA_HI      11
`define RFSW_CMD_SA_LO      8
`define RFSW_CMD_COMPACT    7
`define RFSW_CMD_OP_HI      6
`define RFSW_CMD_OP_LO      5
`define RFSW_OP_WRITE       2'h2
`define RFSW_OP_READ        2'h3

// bit counts, as index of the last bit of each frame
`define RFSW_CMD_LAST       4'hc
`define RFSW_DATA_LAST      4'h8
`define RFSW_RD_PARK        4'h9
`define RFSW_RD_DONE        4'ha

// path-select codes
`define RFSW_PATH_ISO       8'h00
`define RFSW_PATH_RF1       8'h02
`define RFSW_PATH_RF2       8'h0a
`define RFSW_PATH_RF3       8'h0e
`define RFSW_PATH_RF4       8'h0b
`define RFSW_PATH_RF5       8'h01
`define RFSW_PATH_RF6       8'h09
`define RFSW_PATH_RF7       8'h06
`define RFSW_PATH_RF8       8'h04

`endif

// ===== src/rfsw_pkg.sv
// types shared by the rf switch command decoder.
// assumes rfsw_map.svh for all numeric constants.
package rfsw_pkg;

    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_CMD,
        ST_WDATA,
        ST_RPARK,
        ST_RDATA
    } rfsw_state_t;

    // one register write handed from the frame decoder to the register set
    typedef struct packed
    {
        logic       go;
        logic [4:0] addr;
        logic [7:0] data;
    } rfsw_wr_t;

    // synchronised view of one of the two link pins
    typedef struct packed
    {
        logic level;
        logic rise;
        logic fall;
    } rfsw_pin_t;

endpackage

// ===== src/rfsw_pin_sync.sv
// two-flop synchroniser with edge detection for link pins.
// assumes pins are asynchronous to i_clk and slower than half its rate.
`timescale 1ns/1ps
module rfsw_pin_sync #(
    parameter int W = 2
)(
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    // raw pins
    input  wire logic [W-1:0]      i_pins,
    // synchronised levels and one-cycle edge pulses
    output rfsw_pkg::rfsw_pin_t    o_pin [W]
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;

    initial
    begin
        if (W < 1)
            $error("rfsw_pin_sync: W must be at least 1");
    end

    // meta_q feeds sync_q only
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end
        else
        begin
            meta_q <= i_pins;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    for (genvar g = 0; g < W; g++)
    begin : g_pin
        assign o_pin[g].level = sync_q[g];
        assign o_pin[g].rise  = sync_q[g] & ~prev_q[g];
        assign o_pin[g].fall  = ~sync_q[g] & prev_q[g];
    end

endmodule

// ===== src/rfsw_regbank.sv
// slave-side two-wire command decoder and register set of an eight-way
// rf antenna switch.
// assumes the bus clock pin is sampled by i_clk (at least 4x faster) and
// that the data pin wire is resolved outside from o_sdata/o_sdata_oe.
//
// What this block does
// - write is start, node id, 0, 10, address, parity, byte, parity, park.
// - read: 0, 11, address, parity, park; we drive byte, parity, park.
// - compact write: bit 7 set, path bits in 6:0, parity and park.
// - path register at 0x00 resets to zero and obeys triggers 0, 1 and 2.
// - power control bit 7 chooses normal (0) or low power (1).
// - power control bit 6 at one reloads every register with its default.
// - bits 5:3 mask triggers 2:0; writes are direct only with all three masks set.
// - a clear mask sends writes to a shadow until its trigger fires.
// - bits 2:0 are write-only strobes copying shadow to path when unmasked.
// - address 0x1d returns a fixed part code and ignores writes.
// - address 0x1e returns the low byte of the 10-bit maker code.
// - writes to the maker code registers change no maker bits; 0x1f bits 3:0 take the node address.
// - address 0x1f bits 5:4 hold maker code bits 9:8, bits 7:6 read zero.
// - 0x1f bits 3:0 are the node address reads must match (writes also take 0), reset 1011.
// - the path code is decoded to isolation or one of eight rf ports.
`timescale 1ns/1ps
`include "rfsw_map.svh"
module rfsw_regbank #(
    parameter logic [7:0] PART_CODE  = 8'h5a,  // arbitrary value
    parameter logic [9:0] MAKER_CODE = 10'h163, // arbitrary value
    parameter logic [3:0] NODE_RESET = `RFSW_NODE_RST
)(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    // two-wire link
    input  wire logic        i_sclk,
    input  wire logic        i_sdata,
    output logic             o_sdata,
    output logic             o_sdata_oe,
    // switch control
    output logic [7:0]       o_path_select,
    output logic             o_isolated,
    output logic [7:0]       o_rf_port,
    output logic             o_low_power
);

    initial
    begin
        if (NODE_RESET == `RFSW_BCAST_ADDR)
            $error("rfsw_regbank: NODE_RESET must not be the broadcast 0");
    end

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic odd_ok(input logic [12:0] bits);
        odd_ok = ^bits;
    endfunction

    function automatic logic [8:0] decode_path(input logic [7:0] p);
        decode_path = '0;
        case (p)
            `RFSW_PATH_ISO: decode_path[0] = 1'b1;
            `RFSW_PATH_RF1: decode_path[1] = 1'b1;
            `RFSW_PATH_RF2: decode_path[2] = 1'b1;
            `RFSW_PATH_RF3: decode_path[3] = 1'b1;
            `RFSW_PATH_RF4: decode_path[4] = 1'b1;
            `RFSW_PATH_RF5: decode_path[5] = 1'b1;
            `RFSW_PATH_RF6: decode_path[6] = 1'b1;
            `RFSW_PATH_RF7: decode_path[7] = 1'b1;
            `RFSW_PATH_RF8: decode_path[8] = 1'b1;
            default:        decode_path    = 9'h001;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // pin synchronisation
    // ---------------------------------------------------------------
    rfsw_pkg::rfsw_pin_t pin [2];
    rfsw_pkg::rfsw_pin_t scl;
    rfsw_pkg::rfsw_pin_t sda;

    rfsw_pin_sync #(
        .W (2)
    ) u_sync (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_pins    ({i_sdata, i_sclk}),
        .o_pin     (pin)
    );

    assign scl = pin[0];
    assign sda = pin[1];

    // ---------------------------------------------------------------
    // register state
    // ---------------------------------------------------------------
    logic [7:0] path_q;
    logic [7:0] shadow_q;
    logic       low_power_q;
    logic       startup_q;
    logic [2:0] mask_q;
    logic [3:0] node_q;
    logic [8:0] port_q;

    rfsw_pkg::rfsw_wr_t wr_q;

    // ---------------------------------------------------------------
    // sequence start: data pulses high while the clock stays low
    // ---------------------------------------------------------------
    logic ssc_arm_q;
    logic ssc;
    logic oe_q;

    // our own drive is ignored so read data can never look like a start
    assign ssc = sda.fall & ~scl.level & ssc_arm_q & ~oe_q;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            ssc_arm_q <= 1'b0;
        else if (scl.level || oe_q)
            ssc_arm_q <= 1'b0;
        else if (sda.rise)
            ssc_arm_q <= 1'b1;
        else if (ssc)
            ssc_arm_q <= 1'b0;
    end

    // ---------------------------------------------------------------
    // frame decoder
    // ---------------------------------------------------------------
    rfsw_pkg::rfsw_state_t state_q;
    logic [3:0]  cnt_q;
    logic [11:0] shift_q;
    logic [4:0]  addr_q;
    logic [8:0]  rd_word_q;
    logic        sdata_q;
    logic [12:0] cmd_full;
    logic [8:0]  data_full;
    logic [3:0]  sa;
    logic        sa_match;
    logic        rd_match;
    logic [7:0]  rd_byte;

    assign cmd_full  = {shift_q, sda.level};
    assign data_full = {shift_q[7:0], sda.level};
    assign sa        = cmd_full[`RFSW_CMD_SA_HI+1:`RFSW_CMD_SA_LO+1];
    assign sa_match  = (sa == node_q) || (sa == `RFSW_BCAST_ADDR);
    assign rd_match  = (sa == node_q);

    always_comb
    begin
        case (addr_q)
            `RFSW_ADDR_PATH:     rd_byte = path_q;
            `RFSW_ADDR_PMT:      rd_byte = {low_power_q, startup_q,
                                            mask_q, 3'h0};
            `RFSW_ADDR_PART:     rd_byte = PART_CODE;
            `RFSW_ADDR_MAKER_LO: rd_byte = MAKER_CODE[7:0];
            `RFSW_ADDR_MAKER_HI: rd_byte = {2'h0, MAKER_CODE[9:8],
                                            node_q};
            default:             rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_q   <= rfsw_pkg::ST_IDLE;
            cnt_q     <= 4'h0;
            shift_q   <= 12'h000;
            addr_q    <= 5'h00;
            rd_word_q <= 9'h000;
            sdata_q   <= 1'b0;
            oe_q      <= 1'b0;
            wr_q      <= '0;
        end
        else
        begin
            wr_q.go <= 1'b0;
            if (ssc)
            begin
                state_q <= rfsw_pkg::ST_CMD;
                cnt_q   <= 4'h0;
            end
            else
            begin
                case (state_q)
                    rfsw_pkg::ST_IDLE:
                    begin
                        cnt_q <= 4'h0;
                    end
                    rfsw_pkg::ST_CMD:
                    begin
                        if (scl.fall)
                        begin
                            shift_q <= cmd_full[11:0];
                            cnt_q   <= cnt_q + 4'h1;
                            if (cnt_q == `RFSW_CMD_LAST)
                            begin
                                cnt_q   <= 4'h0;
                                state_q <= rfsw_pkg::ST_IDLE;
                                addr_q  <= cmd_full[5:1];
                                if (!odd_ok(cmd_full) || !sa_match)
                                    state_q <= rfsw_pkg::ST_IDLE;
                                else if (cmd_full[`RFSW_CMD_COMPACT+1])
                                begin
                                    // path bit 7 is forced clear
                                    wr_q.go   <= 1'b1;
                                    wr_q.addr <= `RFSW_ADDR_PATH;
                                    wr_q.data <= 8'(cmd_full[7:1]);
                                end
                                else if (cmd_full[7:6] == `RFSW_OP_WRITE)
                                    state_q <= rfsw_pkg::ST_WDATA;
                                else if (cmd_full[7:6] == `RFSW_OP_READ
                                         && rd_match)
                                    state_q <= rfsw_pkg::ST_RPARK;
                            end
                        end
                    end
                    rfsw_pkg::ST_WDATA:
                    begin
                        if (scl.fall)
                        begin
                            shift_q <= {shift_q[10:0], sda.level};
                            cnt_q   <= cnt_q + 4'h1;
                            if (cnt_q == `RFSW_DATA_LAST)
                            begin
                                // trailing park cycle needs no action
                                state_q   <= rfsw_pkg::ST_IDLE;
                                wr_q.go <= odd_ok(13'(data_full));
                                wr_q.addr <= addr_q;
                                wr_q.data <= data_full[8:1];
                            end
                        end
                    end
                    rfsw_pkg::ST_RPARK:
                    begin
                        if (scl.fall)
                        begin
                            state_q   <= rfsw_pkg::ST_RDATA;
                            cnt_q     <= 4'h0;
                            rd_word_q <= {rd_byte, ~^rd_byte};
                        end
                    end
                    rfsw_pkg::ST_RDATA:
                    begin
                        // drive on rising edges, release after the park
                        if (scl.rise && cnt_q <= `RFSW_RD_PARK)
                        begin
                            oe_q      <= 1'b1;
                            sdata_q   <= (cnt_q == `RFSW_RD_PARK) ?
                                         1'b0 : rd_word_q[8];
                            rd_word_q <= {rd_word_q[7:0], 1'b0};
                            cnt_q     <= cnt_q + 4'h1;
                        end
                        else if (scl.fall && cnt_q == `RFSW_RD_DONE)
                        begin
                            oe_q    <= 1'b0;
                            sdata_q <= 1'b0;
                            state_q <= rfsw_pkg::ST_IDLE;
                        end
                    end
                    default:
                    begin
                        state_q <= rfsw_pkg::ST_IDLE;
                        oe_q    <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // register set
    // ---------------------------------------------------------------
    logic [2:0] trig_fire;
    logic       wr_pmt;
    logic       wr_path;

    assign wr_pmt  = wr_q.go && wr_q.addr == `RFSW_ADDR_PMT;
    assign wr_path = wr_q.go && wr_q.addr == `RFSW_ADDR_PATH;
    // strobes only act on triggers whose mask was clear before this write
    assign trig_fire = wr_q.data[`RFSW_PMT_TRIG_HI:`RFSW_PMT_TRIG_LO]
                       & ~mask_q;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            path_q   <= `RFSW_PATH_RST;
            shadow_q <= `RFSW_PATH_RST;
        end
        else if (wr_pmt && wr_q.data[`RFSW_PMT_STARTUP])
        begin
            path_q   <= `RFSW_PATH_RST;
            shadow_q <= `RFSW_PATH_RST;
        end
        else if (wr_path)
        begin
            // path listens to all three triggers; direct only if all off
            if (&mask_q)
                path_q <= wr_q.data;
            else
                shadow_q <= wr_q.data;
        end
        else if (wr_pmt && |trig_fire)
            path_q <= shadow_q;
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            low_power_q <= 1'(`RFSW_PMT_RST >> `RFSW_PMT_LOW_POWER);
            startup_q   <= 1'b0;
            mask_q      <= 3'h0;
        end
        else if (wr_pmt && wr_q.data[`RFSW_PMT_STARTUP])
        begin
            // startup is a one-shot reload, so it never reads back as one
            low_power_q <= 1'b0;
            startup_q   <= 1'b0;
            mask_q      <= 3'h0;
        end
        else if (wr_pmt)
        begin
            low_power_q <= wr_q.data[`RFSW_PMT_LOW_POWER];
            mask_q      <= wr_q.data[`RFSW_PMT_MASK_HI:
                                     `RFSW_PMT_MASK_LO];
        end
    end

    // maker code and part code bits are constants: only the node bits of 0x1f take writes
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            node_q <= NODE_RESET;
        else if (wr_pmt && wr_q.data[`RFSW_PMT_STARTUP])
            node_q <= NODE_RESET;
        else if (wr_q.go && wr_q.addr == `RFSW_ADDR_MAKER_HI)
            node_q <= wr_q.data[3:0];
    end

    // ---------------------------------------------------------------
    // switch driver outputs
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            port_q <= 9'h001;
        else
            port_q <= decode_path(path_q);
    end

    assign o_sdata       = sdata_q;
    assign o_sdata_oe    = oe_q;
    assign o_path_select = path_q;
    assign o_isolated    = port_q[0];
    assign o_rf_port     = port_q[8:1];
    assign o_low_power   = low_power_q;

endmodule

// ===== test/rfsw_regbank_properties.sv
// port assertions of the rf switch register bank.
// assumes a bind onto rfsw_regbank and a link clock well below i_clk.
`timescale 1ns/1ps
module rfsw_regbank_properties (
    // clock and reset
    input wire logic       i_clk,
    input wire logic       i_reset_n,
    // link and switch outputs
    input wire logic       i_sclk,
    input wire logic       o_sdata,
    input wire logic       o_sdata_oe,
    input wire logic [7:0] o_path_select,
    input wire logic       o_isolated,
    input wire logic [7:0] o_rf_port,
    input wire logic       o_low_power
);
    logic       sclk_q;
    logic [3:0] since_q;
    logic [3:0] rises_q;
    wire        rise = i_sclk & ~sclk_q;

    function automatic logic [7:0] port_of(input logic [7:0] p);
        case (p)
            8'h02: port_of = 8'h01;
            8'h0a: port_of = 8'h02;
            8'h0e: port_of = 8'h04;
            8'h0b: port_of = 8'h08;
            8'h01: port_of = 8'h10;
            8'h09: port_of = 8'h20;
            8'h06: port_of = 8'h40;
            8'h04: port_of = 8'h80;
            default: port_of = 8'h00;
        endcase
    endfunction

    // raw pin sampled once only: edges here lead the design's by a flop or two
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            sclk_q <= 1'b0;
            since_q <= 4'hf;
            rises_q <= 4'h0;
        end
        else
        begin
            sclk_q <= i_sclk;
            since_q <= rise ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
            rises_q <= !o_sdata_oe ? 4'h0 : rises_q + {3'h0, rise};
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    sequence s_drive_on;
        $rose(o_sdata_oe);
    endsequence
    sequence s_drive_off;
        $fell(o_sdata_oe);
    endsequence

    AST_RESET_STATE: assert property ($rose(i_reset_n) |->
        o_path_select == 8'h00 && o_isolated && !o_low_power && !o_sdata_oe)
        else $error("outputs not at reset state after reset");
    AST_DRIVE_AFTER_RISE: assert property (
        s_drive_on |-> since_q < 4'h7)
        else $error("data pin driven away from a clock rise");
    AST_DRIVE_HOLDS: assert property (
        s_drive_on |=> o_sdata_oe[*8])
        else $error("data pin released too early");
    AST_DRIVE_SPAN: assert property (
        s_drive_off |-> rises_q == 4'h9)
        else $error("read drive did not span ten bit times");
    AST_BIT_STANDS: assert property (o_sdata_oe && $past(o_sdata_oe) &&
        $changed(o_sdata) |-> since_q < 4'h7)
        else $error("driven bit changed away from a clock rise");
    AST_IDLE_LOW: assert property (!o_sdata_oe |-> !o_sdata)
        else $error("data output not low while undriven");
    AST_PATH_QUIET: assert property ($changed(o_path_select) |->
        !o_sdata_oe ##1 o_rf_port == port_of($past(o_path_select)))
        else $error("path changed in a read or port not following");
    AST_PORT_DECODE: assert property ($stable(o_path_select) |->
        o_rf_port == port_of(o_path_select))
        else $error("rf port does not match path code");
    AST_ISOLATED: assert property (
        o_isolated == (o_rf_port == 8'h00))
        else $error("isolation flag disagrees with rf port");
    AST_POWER_QUIET: assert property (
        $changed(o_low_power) |-> !o_sdata_oe)
        else $error("power mode changed during a read");
endmodule

bind rfsw_regbank rfsw_regbank_properties rfsw_regbank_properties_i (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_sclk(i_sclk),
    .o_sdata(o_sdata), .o_sdata_oe(o_sdata_oe),
    .o_path_select(o_path_select), .o_isolated(o_isolated),
    .o_rf_port(o_rf_port), .o_low_power(o_low_power));

// ===== test/rfsw_master_model.sv
// bus master model that drives the two-wire link of the register bank.
// assumes the device's data and enable come in; resolves the data wire.
`timescale 1ns/1ps
module rfsw_master_model (
    // device drive of the data pin
    input  wire logic i_dev_sdata,
    input  wire logic i_dev_oe,
    // resolved link pins
    output logic      o_sclk,
    output wire logic o_sdata
);
    logic drv_q = 1'b0;

    assign o_sdata = i_dev_oe ? i_dev_sdata : drv_q;
    initial o_sclk = 1'b0;

    // data moves while the clock is high; the device samples on the fall
    task automatic bit_out(input logic b);
        o_sclk = 1'b1;
        drv_q = b;
        #40;
        o_sclk = 1'b0;
        #40;
    endtask

    // odd offset walks the link edges across the system clock's phase
    task automatic frame(input logic [21:0] bits, input int n);
        #103;
        drv_q = 1'b1;
        #20;
        drv_q = 1'b0;
        #20;
        for (int i = n - 1; i >= 0; i--)
            bit_out(bits[i]);
        bit_out(1'b0);
    endtask

    task automatic wr(input logic [3:0] sa, input logic [4:0] a,
                      input logic [7:0] d, input logic [1:0] bad);
        logic [11:0] c;
        c = {sa, 3'b010, a};
        frame({c, ~^c ^ bad[1], d, ~^d ^ bad[0]}, 22);
    endtask

    task automatic cw(input logic [3:0] sa, input logic [6:0] d);
        frame({9'h0, sa, 1'b1, d, ~^{sa, 1'b1, d}}, 13);
    endtask

    // while released the line shows the inverse of the park level until the park bit
    task automatic rd(input logic [3:0] sa, input logic [4:0] a,
                      output logic [9:0] got);
        logic [11:0] c;
        c = {sa, 3'b011, a};
        frame({9'h0, c, ~^c}, 13);
        for (int i = 9; i >= 0; i--)
        begin
            o_sclk = 1'b1;
            drv_q = (i != 0);
            #38;
            got[i] = o_sdata;
            #2;
            o_sclk = 1'b0;
            #40;
        end
    endtask
endmodule

// ===== test/rfsw_regbank_bench.sv
// self-checking bench of the rf switch register bank.
// assumes rfsw_master_model on the link and the checker bound separately.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        n_compared++; \
        if ((g) !== (e)) \
        begin \
            bad_count++; \
            $display("wrong value %s exp %h got %h", nm, e, g); \
        end \
    end
module rfsw_regbank_bench;
    localparam logic [7:0] PART  = 8'h3c;  // arbitrary value
    localparam logic [9:0] MAKER = 10'h2a5; // arbitrary value
    localparam logic [3:0] NODE  = 4'hb;
    logic       i_clk     = 1'b0;
    logic       i_reset_n = 1'b0;
    wire logic  sclk;
    wire logic  sdata;
    logic       o_sdata;
    logic       o_sdata_oe;
    logic [7:0] o_path_select;
    logic       o_isolated;
    logic [7:0] o_rf_port;
    logic       o_low_power;
    logic [7:0] prev;
    logic [7:0] d;
    logic [3:0] sa;
    logic [1:0] bad;
    int         kind;
    int         bad_count  = 0;
    int         n_compared = 0;
    logic [7:0] codes [9] = '{8'h00, 8'h02, 8'h0a, 8'h0e, 8'h0b,
                              8'h01, 8'h09, 8'h06, 8'h04};

    rfsw_regbank #(.PART_CODE(PART), .MAKER_CODE(MAKER)) rfsw_regbank_i (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_sclk(sclk),
        .i_sdata(sdata), .o_sdata(o_sdata), .o_sdata_oe(o_sdata_oe),
        .o_path_select(o_path_select), .o_isolated(o_isolated),
        .o_rf_port(o_rf_port), .o_low_power(o_low_power));
    rfsw_master_model rfsw_master_model_i (
        .i_dev_sdata(o_sdata), .i_dev_oe(o_sdata_oe),
        .o_sclk(sclk), .o_sdata(sdata));

    initial
    begin
        forever #5 i_clk = ~i_clk;
    end

    task automatic print_verdict();
        $display("compared %0d wrong %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic wr_reg(input logic [3:0] s, input logic [4:0] a,
                          input logic [7:0] v);
        rfsw_master_model_i.wr(s, a, v, 2'b00);
    endtask

    // byte, odd parity, then a low park bit
    task automatic rd_reg(input logic [3:0] s, input logic [4:0] a,
                          input logic [7:0] e);
        logic [9:0] got;
        rfsw_master_model_i.rd(s, a, got);
        `CHK("read", {e, ~^e, 1'b0}, got)
    endtask

    initial
    begin
        #800000;
        bad_count++;
        print_verdict();
    end

    initial
    begin
        void'($urandom(32'h997fbcc9));
        repeat (16) @(posedge i_clk);
        @(negedge i_clk);
        i_reset_n = 1'b1;
        repeat (4) @(negedge i_clk);
        `CHK("path", 8'h00, o_path_select)
        `CHK("iso", 1'b1, o_isolated)
        rd_reg(NODE, 5'h1c, 8'h00);
        rd_reg(NODE, 5'h1d, PART);
        rd_reg(NODE, 5'h1e, MAKER[7:0]);
        rd_reg(NODE, 5'h1f, {2'b00, MAKER[9:8], NODE});
        rd_reg(NODE, 5'h05, 8'h00);
        prev = 8'h00;
        for (int t = 0; t < 3; t++)
        begin
            wr_reg(NODE, 5'h00, codes[t + 1]);
            `CHK("shadow", prev, o_path_select)
            wr_reg(NODE, 5'h1c, 8'h00);
            `CHK("no strobe", prev, o_path_select)
            wr_reg(NODE, 5'h1c, 8'h01 << t);
            `CHK("strobe", codes[t + 1], o_path_select)
            prev = codes[t + 1];
        end
        wr_reg(NODE, 5'h1c, 8'h38);
        rd_reg(NODE, 5'h1c, 8'h38);
        for (int k = 0; k < 9; k++)
        begin
            wr_reg(NODE, 5'h00, codes[k]);
            `CHK("direct", codes[k], o_path_select)
            `CHK("port", 9'h001 << k >> 1, o_rf_port)
            `CHK("iso", k == 0, o_isolated)
        end
        rd_reg(NODE, 5'h00, 8'h04);
        wr_reg(NODE, 5'h00, 8'hff);
        rfsw_master_model_i.cw(NODE, 7'h7f);
        `CHK("compact", 8'h7f, o_path_select)
        prev = 8'h7f;
        for (int n = 0; n < 24; n++)
        begin
            d = 8'($urandom);
            kind = $urandom % 5;
            sa = 4'h1 + 4'($urandom % 10);
            bad = 2'($urandom_range(1, 3));
            case (kind)
                0: wr_reg(NODE, 5'h00, d);
                1: rfsw_master_model_i.cw(NODE, d[6:0]);
                2: rfsw_master_model_i.wr(NODE, 5'h00, d, bad);
                3: wr_reg(sa, 5'h00, d);
                default: wr_reg(4'h0, 5'h00, d);
            endcase
            if (kind == 0 || kind == 4)
                prev = d;
            if (kind == 1)
                prev = {1'b0, d[6:0]};
            `CHK("path", prev, o_path_select)
        end
        wr_reg(NODE, 5'h1c, 8'hb8);
        `CHK("low power", 1'b1, o_low_power)
        rd_reg(NODE, 5'h1c, 8'hb8);
        wr_reg(NODE, 5'h1d, ~PART);
        rd_reg(NODE, 5'h1d, PART);
        wr_reg(NODE, 5'h1e, ~MAKER[7:0]);
        rd_reg(NODE, 5'h1e, MAKER[7:0]);
        wr_reg(NODE, 5'h1f, 8'hf5);
        rd_reg(4'h5, 5'h1f, {2'b00, MAKER[9:8], 4'h5});
        wr_reg(NODE, 5'h00, ~prev);
        `CHK("old node", prev, o_path_select)
        wr_reg(4'h5, 5'h1c, 8'h40);
        `CHK("startup path", 8'h00, o_path_select)
        `CHK("startup power", 1'b0, o_low_power)
        rd_reg(NODE, 5'h1c, 8'h00);
        rd_reg(NODE, 5'h1f, {2'b00, MAKER[9:8], NODE});
        print_verdict();
    end
endmodule
